// [cfs_supervisor.sv]
`timescale 1ns/1ps
// Contract
// - Fan control mode is one setting, 0 always-on, 1 run-linked.
// - Mode 0 turns the fan on at power up, ignoring run command.
// - Mode 0 turns fan off only on main circuit undervoltage.
// - Mode 1 starts fan only with power present and either run asserted or heatsink over temperature.
// - Mode 1 stops fan when run is off and output shut off.
// - Mode 1 keeps fan on while heatsink is over temperature.
// - Fan trip action setting: 0 continue, 1 stop.
// - Trip action 0 never stops the drive on a fan trip.
// - Output function 18 drives the fan fault alarm under trip action 0.
// - Trip action 1 stops the drive and shows a fan fault.
// - Output function 17 signals general fault when fan fault stops drive.
// - Output terminal function ranges 0 to 18, resets to 12.
// - Relay function ranges 0 to 18, resets to 17.
module cfs_supervisor
  import cfs_pkg::*;
(
  // Clock and reset
  input  wire logic                      CLK_I,
  input  wire logic                      RST_I,
  // Settings and fault clear
  input  wire logic                      FAN_MODE_WR_I,
  input  wire logic                      FAN_MODE_I,
  input  wire logic                      TRIP_ACTION_WR_I,
  input  wire logic                      TRIP_ACTION_I,
  input  wire logic                      TERM_FUNC_WR_I,
  input  wire logic [cfs_pkg::FUNC_W-1:0] TERM_FUNC_I,
  input  wire logic                      RELAY_FUNC_WR_I,
  input  wire logic [cfs_pkg::FUNC_W-1:0] RELAY_FUNC_I,
  input  wire logic                      FAULT_CLR_I,
  // Drive status
  input  wire logic                      RUN_CMD_I,
  input  wire logic                      OUT_SHUTOFF_I,
  input  wire logic                      UNDERVOLT_I,
  input  wire logic                      HEATSINK_HOT_I,
  input  wire logic                      FAN_FAULT_I,
  // Setting readback
  output logic                           FAN_MODE_O,
  output logic                           TRIP_ACTION_O,
  output logic      [cfs_pkg::FUNC_W-1:0] TERM_FUNC_O,
  output logic      [cfs_pkg::FUNC_W-1:0] RELAY_FUNC_O,
  // Actions
  output logic                           FAN_ON_O,
  output logic                           RUN_STOP_REQ_O,
  output logic                           FAN_FAULT_DISP_O,
  output logic                           FAN_ALARM_O,
  output logic                           TERM_OUT_O,
  output logic                           RELAY_OUT_O
);
  import cfs_pkg::*;

  logic           hot;
  logic           fan_flt;
  cfs_fan_state_t state;
  cfs_fan_state_t next_state;
  logic           trip;

  // Status flags taken each cycle, synchronous inputs
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      hot     <= 1'b0;
      fan_flt <= 1'b0;
    end else begin
      hot     <= HEATSINK_HOT_I;
      fan_flt <= FAN_FAULT_I;
    end
  end

  // Single-bit mode settings; 1-bit width keeps range legal
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      FAN_MODE_O    <= MODE_ALWAYS;
      TRIP_ACTION_O <= TRIP_CONTINUE;
    end else begin
      if (FAN_MODE_WR_I) begin
        FAN_MODE_O <= FAN_MODE_I;
      end
      if (TRIP_ACTION_WR_I) begin
        TRIP_ACTION_O <= TRIP_ACTION_I;
      end
    end
  end

  // Fan demand in each mode
  wire power_ok   = ~UNDERVOLT_I;
  wire link_start = power_ok & (RUN_CMD_I | hot);
  wire link_stop  = ~RUN_CMD_I & OUT_SHUTOFF_I & ~hot;
  wire mode_link  = (FAN_MODE_O == MODE_LINKED);

  // Fan state machine; undervoltage always wins as power is gone
  always_comb begin
    next_state = state;
    case (state)
      CFS_OFF: begin
        if (!mode_link && power_ok) begin
          next_state = CFS_ON;
        end else if (mode_link && link_start) begin
          next_state = CFS_ON;
        end
      end
      CFS_ON: begin
        if (UNDERVOLT_I) begin
          next_state = CFS_OFF;
        end else if (mode_link && link_stop) begin
          next_state = CFS_OFF;
        end
      end
      default: next_state = CFS_OFF;
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state <= CFS_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Trip latch: held until cleared, a new fault beats the clear
  wire stop_sel   = (TRIP_ACTION_O == TRIP_STOP);
  wire next_trip  = (fan_flt & stop_sel) | (trip & ~FAULT_CLR_I);
  wire next_fan   = (next_state == CFS_ON);

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      trip             <= 1'b0;
      FAN_ON_O         <= 1'b0;
      RUN_STOP_REQ_O   <= 1'b0;
      FAN_FAULT_DISP_O <= 1'b0;
      FAN_ALARM_O      <= 1'b0;
    end else begin
      trip             <= next_trip;
      FAN_ON_O         <= next_fan;
      RUN_STOP_REQ_O   <= next_trip;
      FAN_FAULT_DISP_O <= next_trip;
      FAN_ALARM_O      <= fan_flt;
    end
  end

  // Alarm only meaningful while running on; general fault on trip
  wire alarm_src = fan_flt & ~stop_sel;

  // Output terminal, resets to 12
  cfs_out_sel #(.W(FUNC_W), .RESET(TERM_RESET)) u_term (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .wr_i    (TERM_FUNC_WR_I),
    .func_i  (TERM_FUNC_I),
    .fault_i (trip),
    .alarm_i (alarm_src),
    .func_o  (TERM_FUNC_O),
    .pin_o   (TERM_OUT_O)
  );

  // Relay, resets to 17
  cfs_out_sel #(.W(FUNC_W), .RESET(RELAY_RESET)) u_relay (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .wr_i    (RELAY_FUNC_WR_I),
    .func_i  (RELAY_FUNC_I),
    .fault_i (trip),
    .alarm_i (alarm_src),
    .func_o  (RELAY_FUNC_O),
    .pin_o   (RELAY_OUT_O)
  );
endmodule // cfs_supervisor

// [cfs_pkg.sv]
package cfs_pkg;
  // Setting widths and ranges
  localparam int unsigned FUNC_W = 5;
  localparam logic [FUNC_W-1:0] FUNC_MAX       = 5'h12; // 18
  localparam logic [FUNC_W-1:0] FUNC_FAULT_OUT = 5'h11; // 17
  localparam logic [FUNC_W-1:0] FUNC_FAN_ALARM = 5'h12; // 18
  localparam logic [FUNC_W-1:0] TERM_RESET     = 5'h0c; // 12
  localparam logic [FUNC_W-1:0] RELAY_RESET    = 5'h11; // 17
  // Fan control modes
  localparam logic MODE_ALWAYS = 1'b0;
  localparam logic MODE_LINKED = 1'b1;
  // Fan trip actions
  localparam logic TRIP_CONTINUE = 1'b0;
  localparam logic TRIP_STOP     = 1'b1;
  // Fan controller states
  typedef enum logic [1:0] {CFS_OFF, CFS_ON} cfs_fan_state_t;
endpackage

// [cfs_out_sel.sv]
`timescale 1ns/1ps
// One configurable output: latches its function code and drives the pin
module cfs_out_sel #(
  parameter int unsigned       W     = 5,
  parameter logic [W-1:0]      RESET = '0
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Setting
  input  wire logic         wr_i,
  input  wire logic [W-1:0] func_i,
  // Sources
  input  wire logic         fault_i,
  input  wire logic         alarm_i,
  // Results
  output logic      [W-1:0] func_o,
  output logic              pin_o
);
  import cfs_pkg::*;

  wire          in_range = (func_i <= W'(FUNC_MAX));
  wire          sel_flt  = (func_o == W'(FUNC_FAULT_OUT));
  wire          sel_alm  = (func_o == W'(FUNC_FAN_ALARM));
  wire          next_pin = (sel_flt & fault_i) | (sel_alm & alarm_i);

  // Out-of-range writes are dropped so the code stays legal
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      func_o <= RESET;
      pin_o  <= 1'b0;
    end else begin
      if (wr_i && in_range) begin
        func_o <= func_i;
      end
      pin_o <= next_pin;
    end
  end
endmodule // cfs_out_sel

// [cfs_props.sv]
`timescale 1ns/1ps
module cfs_props
  import cfs_pkg::*;
(
  // Clock, reset, drive status and terminal function write
  input wire logic CLK_I, RST_I, RUN_CMD_I, OUT_SHUTOFF_I, UNDERVOLT_I,
  input wire logic HEATSINK_HOT_I, FAN_FAULT_I, TERM_FUNC_WR_I,
  input wire logic [cfs_pkg::FUNC_W-1:0] TERM_FUNC_I,
  // Design outputs
  input wire logic FAN_MODE_O, TRIP_ACTION_O, FAN_ON_O, RUN_STOP_REQ_O,
  input wire logic FAN_FAULT_DISP_O, RELAY_OUT_O,
  input wire logic [cfs_pkg::FUNC_W-1:0] TERM_FUNC_O, RELAY_FUNC_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // Fault seen while stop action is held across the sampling edge
  sequence s_trip;
    TRIP_ACTION_O && FAN_FAULT_I ##1 TRIP_ACTION_O;
  endsequence
  a_trip_stops: assert property (s_trip |=> RUN_STOP_REQ_O &&
    FAN_FAULT_DISP_O) else $error("no stop after fan fault");
  a_cont_no_stop: assert property (!TRIP_ACTION_O &&
    !RUN_STOP_REQ_O |=> !RUN_STOP_REQ_O) else $error("stop in continue");
  a_mode0_on: assert property (!FAN_MODE_O && !UNDERVOLT_I
    |=> FAN_ON_O) else $error("fan off in mode 0");
  a_uv_fan_off: assert property (UNDERVOLT_I |=> !FAN_ON_O)
    else $error("fan on in undervoltage");
  a_run_fan_on: assert property (FAN_MODE_O && RUN_CMD_I &&
    !UNDERVOLT_I |=> FAN_ON_O) else $error("fan off while running");
  a_stop_fan_off: assert property (FAN_MODE_O && !RUN_CMD_I &&
    OUT_SHUTOFF_I && !HEATSINK_HOT_I && !$past(HEATSINK_HOT_I)
    |=> !FAN_ON_O) else $error("fan on after stop");
  a_hot_fan_on: assert property (FAN_MODE_O && !UNDERVOLT_I &&
    $past(HEATSINK_HOT_I) |=> FAN_ON_O) else $error("fan off when hot");
  a_fault_relay: assert property (RELAY_FUNC_O == FUNC_FAULT_OUT &&
    RUN_STOP_REQ_O |=> RELAY_OUT_O) else $error("no fault on relay");
  a_term_reject: assert property (TERM_FUNC_WR_I &&
    TERM_FUNC_I > FUNC_MAX |=> $stable(TERM_FUNC_O)) else $error("bad code");
endmodule // cfs_props
bind cfs_supervisor cfs_props chk (.CLK_I, .RST_I, .RUN_CMD_I,
  .OUT_SHUTOFF_I, .UNDERVOLT_I, .HEATSINK_HOT_I, .FAN_FAULT_I,
  .TERM_FUNC_WR_I, .TERM_FUNC_I, .FAN_MODE_O, .TRIP_ACTION_O, .FAN_ON_O,
  .RUN_STOP_REQ_O, .FAN_FAULT_DISP_O, .RELAY_OUT_O, .TERM_FUNC_O,
  .RELAY_FUNC_O);

// [cfs_fan_mdl.sv]
`timescale 1ns/1ps
// Fan and heatsink: heat builds while no air flows
module cfs_fan_mdl (
  input  wire logic clk_i, fan_on_i, broken_i,
  output logic      hot_o, fault_o
);
  int heat = 0;
  // Changes off the design's sampling edge
  always @(negedge clk_i) begin
    heat <= fan_on_i && !broken_i ? 0 : heat + 1;
    hot_o <= heat > 20;
    fault_o <= fan_on_i && broken_i; // Only a driven fan can stall
  end
endmodule // cfs_fan_mdl

// [tb.sv]
`timescale 1ns/1ps
module tb;
  import cfs_pkg::*;
  logic CLK_I, RST_I, fmw, fm, taw, ta, tw, rw, clr, run, shut, uv, brk;
  logic hot, ff, fmo, tao, fan, stp, dsp, alm, tpo, rpo;
  logic [4:0] tf, rf, tfo, rfo;
  int fail_count = 0, checks_done = 0, cyc = 0, seed = 32'h2e75b835;
  int md, tam, tfm, rfm, fn, trp, h1, f1, al, tp, rp;
  cfs_supervisor uut (.CLK_I, .RST_I, .FAN_MODE_WR_I(fmw), .FAN_MODE_I(fm),
    .TRIP_ACTION_WR_I(taw), .TRIP_ACTION_I(ta), .TERM_FUNC_WR_I(tw),
    .TERM_FUNC_I(tf), .RELAY_FUNC_WR_I(rw), .RELAY_FUNC_I(rf),
    .FAULT_CLR_I(clr), .RUN_CMD_I(run), .OUT_SHUTOFF_I(shut),
    .UNDERVOLT_I(uv), .HEATSINK_HOT_I(hot), .FAN_FAULT_I(ff),
    .FAN_MODE_O(fmo), .TRIP_ACTION_O(tao), .TERM_FUNC_O(tfo),
    .RELAY_FUNC_O(rfo), .FAN_ON_O(fan), .RUN_STOP_REQ_O(stp),
    .FAN_FAULT_DISP_O(dsp), .FAN_ALARM_O(alm), .TERM_OUT_O(tpo),
    .RELAY_OUT_O(rpo));
  cfs_fan_mdl fanm (.clk_i(CLK_I), .fan_on_i(fan), .broken_i(brk),
    .hot_o(hot), .fault_o(ff));
  initial begin
    CLK_I = 0;
    forever #25 CLK_I = ~CLK_I;
  end
  task chk(string n, logic [4:0] e, logic [4:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %0h got %0h", n, e, g);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Pin value per function code; codes with no source stay low
  function int pin(int f);
    return f == 17 ? trp : f == 18 ? (!tam && f1) : 0;
  endfunction
  // Reference model, stepped on the same edge as the design
  always @(posedge CLK_I, posedge RST_I) begin
    if (++cyc > 4000) begin
      fail_count++;
      give_verdict;
    end
    if (RST_I) begin
      md = 0;
      tam = 0;
      fn = 0;
      trp = 0;
      h1 = 0;
      f1 = 0;
      al = 0;
      tp = 0;
      rp = 0;
      tfm = 12;
      rfm = 17;
    end else begin
      tp = pin(tfm);
      rp = pin(rfm);
      al = f1;
      fn = uv ? 0 : !md || run || h1 ? 1 : shut ? 0 : fn;
      h1 = hot;
      trp = tam && f1 ? 1 : clr ? 0 : trp;
      f1 = ff;
      if (fmw) md = fm;
      if (taw) tam = ta;
      if (tw && tf <= 18) tfm = tf;
      if (rw && rf <= 18) rfm = rf;
    end
  end
  initial begin
    {fmw, fm, taw, ta, tw, rw, clr, run, shut, uv, brk} = '0;
    tf = 0;
    rf = 0;
    RST_I = 1;
    repeat (8) @(negedge CLK_I);
    RST_I = 0;
    for (int i = 0; i < 3000; i++) begin
      @(negedge CLK_I);
      chk("mode", md, fmo);
      chk("trip action", tam, tao);
      chk("term func", tfm, tfo);
      chk("relay func", rfm, rfo);
      chk("fan", fn, fan);
      chk("stop", trp, stp);
      chk("display", trp, dsp);
      chk("alarm", al, alm);
      chk("term pin", tp, tpo);
      chk("relay pin", rp, rpo);
      fmw = $random(seed) % 8 == 0;
      taw = $random(seed) % 8 == 0;
      tw = $random(seed) % 4 == 0;
      rw = $random(seed) % 4 == 0;
      {fm, ta, run, shut, tf, rf} = $random(seed);
      uv = $random(seed) % 16 == 0;
      // Stall the fan, then clear only once the fault is gone
      brk = i % 400 inside {[200:299]};
      clr = i % 400 > 350;
    end
    give_verdict;
  end
endmodule // tb
